// File: hw/uart_line_modem_status.sv
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Overrun flag sets when FIFO full on completion
// - Overrun: new character discarded, FIFO untouched
// - Data-ready high while FIFO holds characters
// - Reset clears overrun, data-ready, change bits
// - Modem input change sets its change bit
// - Host read clears all four change bits
// - Bits 7..4 are inverted modem inputs
// - Loop-back: bit 7 returns out2
// - Loop-back: bit 6 returns out1
// - Loop-back: bit 5 returns DTR control
// - Loop-back: bit 4 returns RTS control
// - CD, DSR, CTS change bits: either edge
// - Ring change bit: trailing edge only
// - Modem interrupt set while any change bit set, then held until write-one clear
// - Scratch byte stores host value, no effect
module uart_line_modem_status (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Receiver: completed character from the shift register
  input wire logic i_rx_char_valid,
  input wire logic [7:0] i_rx_char,
  // Modem control pins, active low, asynchronous
  input wire logic i_cd_n,
  input wire logic i_ri_n,
  input wire logic i_dsr_n,
  input wire logic i_cts_n,
  // Modem control outputs, active low
  output logic o_dtr_n,
  output logic o_rts_n,
  output logic o_out1_n,
  output logic o_out2_n,
  // Interrupt
  output logic o_irq
);
  // Pin synchronisers: first stage read only by second
  logic [3:0] pin_meta_reg; // {cd, ri, dsr, cts} active low
  logic [3:0] pin_sync_reg;
  // Register state
  logic [7:0] modem_control_reg;
  logic [7:0] scratch_byte_reg;
  logic [3:0] modem_state_prev_reg; // Previous current-state bits {7..4}
  logic [3:0] modem_delta_reg; // Change-detect bits 3..0
  logic overrun_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_enable_reg;
  // FIFO pointers
  logic [uart_status_pkg::FIFO_AW:0] wr_ptr_reg;
  logic [uart_status_pkg::FIFO_AW:0] rd_ptr_reg;
  logic [uart_status_pkg::FIFO_AW:0] rd_ptr_next;
  logic [7:0] fifo_rd_data;
  // Bus state
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  // Derived signals
  logic loop_mode;
  logic [3:0] modem_state; // {bit7, bit6, bit5, bit4}
  logic [3:0] delta_set;
  logic fifo_full;
  logic fifo_empty;
  logic wr_fire;
  logic rd_take;
  logic rd_modem;
  logic rd_pop;
  logic push;
  logic overrun_evt;
  logic [7:0] line_status;
  logic [2:0] irq_clear;

  // Two-flop synchroniser for the asynchronous modem pins
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta_reg <= 4'hF;
      pin_sync_reg <= 4'hF;
    end else begin
      pin_meta_reg <= {i_cd_n, i_ri_n, i_dsr_n, i_cts_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign loop_mode = modem_control_reg[uart_status_pkg::MC_LOOP];

  // Current-state bits: inverted pins, or modem control in loop-back
  always_comb begin
    if (loop_mode) begin
      modem_state[3] = modem_control_reg[uart_status_pkg::MC_OUT2];
      modem_state[2] = modem_control_reg[uart_status_pkg::MC_OUT1];
      modem_state[1] = modem_control_reg[uart_status_pkg::MC_DTR];
      modem_state[0] = modem_control_reg[uart_status_pkg::MC_RTS];
    end else begin
      modem_state = ~pin_sync_reg;
    end
  end

  // Edge detection on the reported state; ring only on pin rising,
  // which is the reported bit falling
  always_comb begin
    delta_set[3] = modem_state[3] ^ modem_state_prev_reg[3];
    delta_set[2] = modem_state_prev_reg[2] & ~modem_state[2];
    delta_set[1] = modem_state[1] ^ modem_state_prev_reg[1];
    delta_set[0] = modem_state[0] ^ modem_state_prev_reg[0];
  end

  // Previous state tracker; reset matches idle (pins high)
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      modem_state_prev_reg <= 4'h0;
    end else begin
      modem_state_prev_reg <= modem_state;
    end
  end

  // Read handshake decode
  assign rd_take = i_arvalid && !o_rvalid;
  assign rd_modem = rd_take && (i_araddr == uart_status_pkg::ADDR_MODEM_STATUS);
  assign rd_pop = rd_take && (i_araddr == uart_status_pkg::ADDR_RX_DATA) && !fifo_empty;

  // Change-detect bits: a new change wins over the read clear
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      modem_delta_reg <= 4'h0;
    end else if (rd_modem) begin
      modem_delta_reg <= delta_set;
    end else begin
      modem_delta_reg <= modem_delta_reg | delta_set;
    end
  end

  // FIFO status
  assign fifo_empty = (wr_ptr_reg == rd_ptr_reg);
  assign fifo_full = (wr_ptr_reg[uart_status_pkg::FIFO_AW] != rd_ptr_reg[uart_status_pkg::FIFO_AW]) &&
    (wr_ptr_reg[uart_status_pkg::FIFO_AW-1:0] == rd_ptr_reg[uart_status_pkg::FIFO_AW-1:0]);
  assign push = i_rx_char_valid && !fifo_full;
  assign overrun_evt = i_rx_char_valid && fifo_full;
  assign rd_ptr_next = rd_ptr_reg + {{uart_status_pkg::FIFO_AW{1'b0}}, rd_pop};

  // Write pointer: no push while full, so stored data stay intact
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // Read pointer advances on a data read
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_ptr_reg <= '0;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  rx_fifo_mem u_mem (
    .i_core_clk(i_core_clk),
    .i_wr_en(push),
    .i_wr_addr(wr_ptr_reg[uart_status_pkg::FIFO_AW-1:0]),
    .i_wr_data(i_rx_char),
    .i_rd_addr(rd_ptr_next[uart_status_pkg::FIFO_AW-1:0]),
    .o_rd_data(fifo_rd_data)
  );

  // Overrun flag: set wins over the clear by a line status read
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      overrun_reg <= 1'b0;
    end else if (overrun_evt) begin
      overrun_reg <= 1'b1;
    end else if (rd_take && (i_araddr == uart_status_pkg::ADDR_LINE_STATUS)) begin
      overrun_reg <= 1'b0;
    end
  end

  // Line status word; data ready follows FIFO occupancy directly
  always_comb begin
    line_status = 8'h00;
    line_status[uart_status_pkg::LS_DATA_READY] = !fifo_empty;
    line_status[uart_status_pkg::LS_OVERRUN] = overrun_reg;
  end

  // Write channel capture: address and data in either order
  assign wr_fire = aw_held_reg && w_held_reg && !o_bvalid;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (i_awvalid && o_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= i_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= i_wdata;
      w_strb_reg <= i_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Ready outputs registered: each accepts only while its own half is not held
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_awready <= !aw_held_reg && !(i_awvalid && o_awready);
      o_wready <= !w_held_reg && !(i_wvalid && o_wready);
    end
  end

  // Write response; unmapped or read-only addresses answer SLVERR
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bvalid <= 1'b0;
      o_bresp <= uart_status_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      case (aw_addr_reg)
        uart_status_pkg::ADDR_SCRATCH_BYTE,
        uart_status_pkg::ADDR_MODEM_CONTROL,
        uart_status_pkg::ADDR_IRQ_ENABLE,
        uart_status_pkg::ADDR_IRQ_CLEAR: o_bresp <= uart_status_pkg::RESP_OKAY;
        default: o_bresp <= uart_status_pkg::RESP_SLVERR;
      endcase
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Writable registers, low byte lane only
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scratch_byte_reg <= uart_status_pkg::RST_BYTE;
      modem_control_reg <= uart_status_pkg::RST_BYTE;
      irq_enable_reg <= uart_status_pkg::RST_IRQ;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == uart_status_pkg::ADDR_SCRATCH_BYTE) begin
        scratch_byte_reg <= w_data_reg[7:0];
      end
      if (aw_addr_reg == uart_status_pkg::ADDR_MODEM_CONTROL) begin
        modem_control_reg <= {3'h0, w_data_reg[4:0]};
      end
      if (aw_addr_reg == uart_status_pkg::ADDR_IRQ_ENABLE) begin
        irq_enable_reg <= w_data_reg[2:0];
      end
    end
  end

  // Interrupt status: events set, write-one clear, set wins
  assign irq_clear = (wr_fire && w_strb_reg[0] && aw_addr_reg == uart_status_pkg::ADDR_IRQ_CLEAR) ?
    w_data_reg[2:0] : 3'h0;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_status_reg <= uart_status_pkg::RST_IRQ;
    end else begin
      irq_status_reg[uart_status_pkg::IRQ_MODEM] <= (|modem_delta_reg) |
        (irq_status_reg[uart_status_pkg::IRQ_MODEM] & ~irq_clear[uart_status_pkg::IRQ_MODEM]);
      irq_status_reg[uart_status_pkg::IRQ_OVERRUN] <= overrun_evt |
        (irq_status_reg[uart_status_pkg::IRQ_OVERRUN] & ~irq_clear[uart_status_pkg::IRQ_OVERRUN]);
      irq_status_reg[uart_status_pkg::IRQ_DATA] <= push |
        (irq_status_reg[uart_status_pkg::IRQ_DATA] & ~irq_clear[uart_status_pkg::IRQ_DATA]);
    end
  end

  // Interrupt output level from a flop
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // Read answer one cycle after the address is taken
  // Address ready is a flop that mirrors an idle read channel
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_arready <= 1'b1;
    end else if (rd_take) begin
      o_arready <= 1'b0;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= uart_status_pkg::RESP_OKAY;
    end else if (rd_take) begin
      o_rvalid <= 1'b1;
      o_rresp <= uart_status_pkg::RESP_OKAY;
      case (i_araddr)
        uart_status_pkg::ADDR_LINE_STATUS: o_rdata <= {24'h0, line_status};
        uart_status_pkg::ADDR_MODEM_STATUS: o_rdata <= {24'h0, modem_state, modem_delta_reg};
        uart_status_pkg::ADDR_SCRATCH_BYTE: o_rdata <= {24'h0, scratch_byte_reg};
        uart_status_pkg::ADDR_MODEM_CONTROL: o_rdata <= {24'h0, modem_control_reg};
        uart_status_pkg::ADDR_IRQ_STATUS: o_rdata <= {29'h0, irq_status_reg};
        uart_status_pkg::ADDR_IRQ_ENABLE: o_rdata <= {29'h0, irq_enable_reg};
        uart_status_pkg::ADDR_IRQ_CLEAR: o_rdata <= 32'h0000_0000;
        uart_status_pkg::ADDR_RX_DATA: o_rdata <= {24'h0, fifo_rd_data};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= uart_status_pkg::RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Modem control pins; loop-back keeps them inactive (high)
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dtr_n <= 1'b1;
      o_rts_n <= 1'b1;
      o_out1_n <= 1'b1;
      o_out2_n <= 1'b1;
    end else begin
      o_dtr_n <= loop_mode | ~modem_control_reg[uart_status_pkg::MC_DTR];
      o_rts_n <= loop_mode | ~modem_control_reg[uart_status_pkg::MC_RTS];
      o_out1_n <= loop_mode | ~modem_control_reg[uart_status_pkg::MC_OUT1];
      o_out2_n <= loop_mode | ~modem_control_reg[uart_status_pkg::MC_OUT2];
    end
  end
endmodule

// File: hw/uart_status_pkg.sv
package uart_status_pkg;
  // Byte addresses of the register words
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODEM_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SCRATCH_BYTE = 8'h08;
  localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_RX_DATA = 8'h1C;
  // Field positions
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int IRQ_MODEM = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_DATA = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  // Receive FIFO depth
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hw/rx_fifo_mem.sv
`timescale 1ns/1ps
// Receive character store; read data leave through a register
module rx_fifo_mem (
  // Clock
  input wire logic i_core_clk,
  // Write port
  input wire logic i_wr_en,
  input wire logic [uart_status_pkg::FIFO_AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  // Read port
  input wire logic [uart_status_pkg::FIFO_AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  logic [7:0] mem [uart_status_pkg::FIFO_DEPTH]; // Storage array, no reset needed

  // Write side
  always_ff @(posedge i_core_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read of the head
  always_ff @(posedge i_core_clk) begin
    o_rd_data <= mem[i_rd_addr];
  end
endmodule

// File: verification/modem_peer.sv
`timescale 1ns/1ps
// Modem side: drives the active-low control lines
module modem_peer (
  // Clock
  input wire logic i_core_clk,
  // Asserted lines wanted {cd, ri, dsr, cts}
  input wire logic [3:0] i_want,
  // Lines toward the device
  output logic o_cd_n,
  output logic o_ri_n,
  output logic o_dsr_n,
  output logic o_cts_n
);
  // Idle lines sit deasserted
  initial {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} = 4'hF;
  // Registered like a real modem output, one edge after the request
  always @(posedge i_core_clk) begin
    {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} <= ~i_want;
  end
endmodule

// File: verification/uart_status_chk.sv
`timescale 1ns/1ps
// Handshake and read data checks at the top ports
module uart_status_chk (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Write side
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  // Read side
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  // Interrupt
  input wire logic o_irq
);
  // Address of the read in flight, to judge its data
  logic [7:0] rd_addr_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_addr_reg <= 8'h00;
    end else if (i_arvalid && o_arready) begin
      rd_addr_reg <= i_araddr;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // Both write halves taken on one edge
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  // Response offered but not yet accepted
  sequence s_b_wait;
    o_bvalid && !i_bready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:3] o_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_b_wait |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  AST_RD_ANSWER: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  AST_AR_BUSY: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  AST_ERR_ZERO: assert property (o_rvalid && o_rresp == 2'h2 |-> o_rdata == 32'h0)
    else $error("error read carries data");
  AST_UPPER_ZERO: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_LS_BITS: assert property (o_rvalid && rd_addr_reg == 8'h00 |-> o_rdata[7:2] == 6'h0)
    else $error("line status extra bits");
  AST_RST_QUIET: assert property ($rose(i_rstn) |-> !o_irq && !o_bvalid && !o_rvalid)
    else $error("outputs busy after reset");
endmodule
bind uart_line_modem_status uart_status_chk chk_inst (.*);

// File: verification/uart_line_modem_status_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the status block
module uart_line_modem_status_tb;
  // Design inputs, all set at time zero
  logic i_core_clk = 1'b0, i_rstn = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0, i_rx_char_valid = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, i_rx_char = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF, want = 4'h0;
  // Design outputs and modem lines
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_dtr_n, o_rts_n, o_out1_n, o_out2_n;
  logic i_cd_n, i_ri_n, i_dsr_n, i_cts_n;
  logic [1:0] o_bresp, o_rresp, rs;
  logic [31:0] o_rdata, rd;
  int bad_count = 0, checks = 0, cyc = 0;
  // Plain register cases: write flag, address, data or expected data, response
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] s;} row_t;
  row_t rows[8] = '{'{1'b0, 8'h00, 32'h0, 2'h0}, '{1'b0, 8'h04, 32'h0, 2'h0},
    '{1'b1, 8'h08, 32'hA5, 2'h0}, '{1'b0, 8'h08, 32'hA5, 2'h0}, '{1'b1, 8'h08, 32'h5A, 2'h0},
    '{1'b0, 8'h08, 32'h5A, 2'h0}, '{1'b1, 8'h00, 32'h3, 2'h2}, '{1'b0, 8'h40, 32'h0, 2'h2}};
  // Modem line steps and the modem status each should give
  logic [3:0] mw[4] = '{4'h1, 4'h5, 4'h1, 4'h3};
  logic [7:0] me[4] = '{8'h11, 8'h50, 8'h14, 8'h32};
  uart_line_modem_status uart_line_modem_status_inst (.*);
  modem_peer modem_peer_inst (.i_core_clk(i_core_clk), .i_want(want), .o_cd_n(i_cd_n), .o_ri_n(i_ri_n),
    .o_dsr_n(i_dsr_n), .o_cts_n(i_cts_n));
  // 20 MHz clock
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write: both halves offered together, each released when taken
  task automatic w_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left, w_left;
    @(posedge i_core_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    aw_left = 1'b1;
    w_left = 1'b1;
    while (aw_left || w_left) begin
      @(posedge i_core_clk);
      if (aw_left && o_awready) begin
        aw_left = 1'b0;
        i_awvalid <= 1'b0;
      end
      if (w_left && o_wready) begin
        w_left = 1'b0;
        i_wvalid <= 1'b0;
      end
    end
    while (o_bvalid !== 1'b1) @(posedge i_core_clk);
    // Ready raised only once the answer is seen, so the slave must hold it
    i_bready <= 1'b1;
    @(posedge i_core_clk);
    r = o_bresp;
    i_bready <= 1'b0;
  endtask
  // Bus read, waiting on the slave's own answer
  task automatic r_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_core_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    @(posedge i_core_clk);
    while (o_arready !== 1'b1) @(posedge i_core_clk);
    i_arvalid <= 1'b0;
    @(posedge i_core_clk);
    while (o_rvalid !== 1'b1) @(posedge i_core_clk);
    // Late ready: the read data must stand until taken
    i_rready <= 1'b1;
    @(posedge i_core_clk);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask
  // One completed character, a single-cycle pulse
  task automatic push(input logic [7:0] v);
    @(posedge i_core_clk);
    i_rx_char_valid <= 1'b1;
    i_rx_char <= v;
    @(posedge i_core_clk);
    i_rx_char_valid <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    foreach (rows[k]) begin
      if (rows[k].wr) begin
        w_reg(rows[k].a, rows[k].d, rs);
      end else begin
        r_reg(rows[k].a, rd, rs);
        chk("rdata", rows[k].d, rd);
      end
      chk("resp", {30'h0, rows[k].s}, {30'h0, rs});
    end
    $display("test table done");
    for (int k = 0; k < 4; k++) begin
      want <= mw[k];
      repeat (6) @(posedge i_core_clk);
      r_reg(uart_status_pkg::ADDR_MODEM_STATUS, rd, rs);
      chk("modem", {24'h0, me[k]}, rd);
    end
    r_reg(uart_status_pkg::ADDR_MODEM_STATUS, rd, rs);
    chk("modem reread", 32'h30, rd);
    $display("test modem done");
    // Drop the modem bit left sticky by the modem test first
    w_reg(uart_status_pkg::ADDR_IRQ_CLEAR, 32'h1, rs);
    w_reg(uart_status_pkg::ADDR_IRQ_ENABLE, 32'h1, rs);
    repeat (2) @(posedge i_core_clk);
    chk("irq idle", 32'h0, {31'h0, o_irq});
    want <= 4'hB;
    // Peer, two sync stages, change bit, status, output flop
    repeat (7) @(posedge i_core_clk);
    chk("irq on", 32'h1, {31'h0, o_irq});
    r_reg(uart_status_pkg::ADDR_MODEM_STATUS, rd, rs);
    chk("modem cd", 32'hB8, rd);
    w_reg(uart_status_pkg::ADDR_IRQ_CLEAR, 32'h1, rs);
    repeat (3) @(posedge i_core_clk);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    w_reg(uart_status_pkg::ADDR_IRQ_ENABLE, 32'h0, rs);
    want <= 4'h3;
    repeat (6) @(posedge i_core_clk);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    r_reg(uart_status_pkg::ADDR_MODEM_STATUS, rd, rs);
    chk("modem cd off", 32'h38, rd);
    $display("test irq done");
    w_reg(uart_status_pkg::ADDR_MODEM_CONTROL, 32'h1F, rs);
    r_reg(uart_status_pkg::ADDR_MODEM_STATUS, rd, rs);
    chk("loop all", 32'hF0, rd & 32'hF0);
    chk("pins loop", 32'hF, {28'h0, o_out2_n, o_out1_n, o_rts_n, o_dtr_n});
    w_reg(uart_status_pkg::ADDR_MODEM_CONTROL, 32'h15, rs);
    r_reg(uart_status_pkg::ADDR_MODEM_STATUS, rd, rs);
    chk("loop some", 32'h60, rd & 32'hF0);
    w_reg(uart_status_pkg::ADDR_MODEM_CONTROL, 32'h0F, rs);
    repeat (2) @(posedge i_core_clk);
    chk("pins on", 32'h0, {28'h0, o_out2_n, o_out1_n, o_rts_n, o_dtr_n});
    r_reg(uart_status_pkg::ADDR_MODEM_CONTROL, rd, rs);
    chk("modem control", 32'hF, rd);
    r_reg(uart_status_pkg::ADDR_MODEM_STATUS, rd, rs);
    chk("normal again", 32'h30, rd & 32'hF0);
    $display("test loop done");
    for (int i = 0; i < 32; i++) push(i[7:0]);
    r_reg(uart_status_pkg::ADDR_LINE_STATUS, rd, rs);
    chk("full", 32'h1, rd);
    push(8'hEE);
    r_reg(uart_status_pkg::ADDR_LINE_STATUS, rd, rs);
    chk("overrun", 32'h3, rd);
    for (int i = 0; i < 32; i++) begin
      r_reg(uart_status_pkg::ADDR_RX_DATA, rd, rs);
      chk("fifo", i, rd);
    end
    r_reg(uart_status_pkg::ADDR_LINE_STATUS, rd, rs);
    chk("empty", 32'h0, rd);
    r_reg(uart_status_pkg::ADDR_IRQ_STATUS, rd, rs);
    chk("irq status", 32'h7, rd);
    w_reg(uart_status_pkg::ADDR_IRQ_CLEAR, 32'h7, rs);
    r_reg(uart_status_pkg::ADDR_IRQ_STATUS, rd, rs);
    chk("irq status cleared", 32'h0, rd);
    $display("test overrun done");
    // Reset in mid-run with a character stored and change bits set
    want <= 4'h0;
    push(8'h11);
    repeat (6) @(posedge i_core_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    r_reg(uart_status_pkg::ADDR_LINE_STATUS, rd, rs);
    chk("reset line", 32'h0, rd);
    r_reg(uart_status_pkg::ADDR_MODEM_STATUS, rd, rs);
    chk("reset modem", 32'h0, rd);
    $display("test reset done");
    complete_run();
  end
endmodule
